// File: rtl/trap_and_global_level_state.v
`timescale 1ns/10ps
`include "trap_state_defines.vh"
// Operation
// RULE1: Trap depth zero means normal operation; above zero means traps in progress.
// RULE2: Trap depth never exceeds max_trap_depth, which is two.
// RULE3: Privileged write of 3 to 7 to trap depth stores 2, no exception.
// RULE4: Only bits 1:0 of trap-depth write data are kept; clamp applies first.
// RULE5: Direct trap-depth write changes nothing else, no save or restore.
// RULE6: Software must not run nonprivileged code with nonzero trap depth.
// RULE7: Leveled interrupt accepted only when its level exceeds the threshold.
// RULE8: Higher interrupt level numbers have higher priority.
// RULE9: Trap entry saves global-set level at current depth, then increments it.
// RULE10: Trap return reloads global-set level from entry at current depth.
// RULE11: Global-set level stays within 0 to max_global_set, which is two.
// RULE12: Global-set level is 3 bits; unimplemented bits read zero.
// RULE13: Trap depth and global-set level are independent counters.
// RULE14: Global-set level is privileged register 16; write switches visible set.
// RULE15: Privileged write above max_global_set stores max_global_set, no exception.
// RULE16: Trap return restores whatever the saved state holds now.
// RULE17: Trap entry increments trap depth; trap return decrements it.
// RULE18: Nonprivileged write raises priv_instr_violation and leaves register unchanged.
module trap_and_global_level_state #(
  parameter INT_LW = 4
) (
  input  wire                     clk_i,
  input  wire                     reset_n_i,
  input  wire                     priv_mode_i,
  input  wire                     wr_en_i,
  input  wire [4:0]               wr_reg_i,
  input  wire [63:0]              wr_data_i,
  input  wire [4:0]               rd_reg_i,
  output reg  [63:0]              rd_data_o,
  input  wire                     trap_entry_i,
  input  wire                     trap_return_i,
  input  wire                     saved_gl_wr_i,
  input  wire [1:0]               saved_gl_idx_i,
  input  wire [2:0]               saved_gl_data_i,
  output wire [2:0]               saved_gl_o,
  input  wire [(1<<INT_LW)-1:0]   int_pending_i,
  output wire                     int_take_o,
  output wire [INT_LW-1:0]        int_level_o,
  output wire [1:0]               trap_depth_o,
  output wire                     in_trap_o,
  output wire [2:0]               global_set_level_o,
  output reg                      priv_instr_violation_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  reg [`TRAP_DEPTH_W-1:0] trap_depth_q;
  reg [`TRAP_DEPTH_W-1:0] trap_depth_d;
  reg [1:0]               gl_q;
  reg [1:0]               gl_d;
  reg [INT_LW-1:0]        threshold_q;
  reg [INT_LW-1:0]        threshold_d;
  reg                     viol_d;
  reg [1:0]               wr_td_low;
  reg [2:0]               wr_gl_val;
  wire [2:0]              restore_gl;
  wire                    mem_wr;
  wire [1:0]              mem_wr_addr;
  wire [2:0]              mem_wr_data;
  wire [1:0]              mem_rd_addr;
  wire                    wr_td;
  wire                    wr_gl;
  wire                    wr_pil;

  assign wr_td  = wr_en_i && (wr_reg_i == `PREG_TRAP_DEPTH);
  assign wr_gl  = wr_en_i && (wr_reg_i == `PREG_GLOBAL_SET);
  assign wr_pil = wr_en_i && (wr_reg_i == `PREG_INT_THRESHOLD);

  // ****************************************************************
  // Saved trap state store
  // ****************************************************************
  // Hardware save on trap entry takes priority over software update
  assign mem_wr      = trap_entry_i || saved_gl_wr_i;
  // Entry is saved at the incremented depth, where the matching return reads it
  assign mem_wr_addr = trap_entry_i ? trap_depth_d : saved_gl_idx_i; // see RULE9
  assign mem_wr_data = trap_entry_i ? {1'b0, gl_q} : saved_gl_data_i;
  assign mem_rd_addr = trap_return_i ? trap_depth_q : saved_gl_idx_i;

  saved_gl_mem #(
    .DEPTH (3),
    .AW    (2),
    .DW    (3)
  ) u_saved_gl (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .wr_en_i   (mem_wr),
    .wr_addr_i (mem_wr_addr),
    .wr_data_i (mem_wr_data),
    .rd_addr_i (mem_rd_addr),
    .rd_data_o (restore_gl)
  );

  assign saved_gl_o = restore_gl;

  // Combinational read of the addressed entry for trap return
  reg [2:0] ret_gl;
  reg [2:0] ret_clamp;
  reg [2:0] ret_mem [0:2];
  integer   k;

  // Shadow copy used for same-cycle restore on trap return
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (k = 0; k < 3; k = k + 1)
        ret_mem[k] <= 3'h0;
    end
    else if (mem_wr && (mem_wr_addr < 2'h3))
      ret_mem[mem_wr_addr] <= mem_wr_data;
  end

  // Current contents, whatever software left there
  always @*
  begin
    ret_gl = 3'h0;
    if (trap_depth_q < 2'h3)
      ret_gl = ret_mem[trap_depth_q]; // see RULE16
    // Out-of-range saved values restore as the top set
    ret_clamp = (ret_gl > `MAX_GLOBAL_SET) ? `MAX_GLOBAL_SET : ret_gl;
  end

  // ****************************************************************
  // Write decode and next-state
  // ****************************************************************
  always @*
  begin
    trap_depth_d = trap_depth_q;
    gl_d         = gl_q;
    threshold_d  = threshold_q;
    viol_d       = 1'b0;
    // Clamp on the full value first, then keep the low two bits
    wr_td_low    = (wr_data_i > {62'h0, `MAX_TRAP_DEPTH}) ? `MAX_TRAP_DEPTH
                                                          : wr_data_i[1:0]; // see RULE4
    wr_gl_val    = (wr_data_i > {61'h0, `MAX_GLOBAL_SET}) ? `MAX_GLOBAL_SET
                                                          : wr_data_i[2:0]; // see RULE15
    if (trap_entry_i)
    begin
      // Saturating increments, each counter on its own
      if (trap_depth_q < `MAX_TRAP_DEPTH)
        trap_depth_d = trap_depth_q + 2'h1; // see RULE17
      if ({1'b0, gl_q} < `MAX_GLOBAL_SET)
        gl_d = gl_q + 2'h1; // see RULE9
    end
    else if (trap_return_i)
    begin
      if (trap_depth_q != 2'h0)
        trap_depth_d = trap_depth_q - 2'h1; // see RULE17
      gl_d = ret_clamp[1:0]; // see RULE10
    end
    else if ((wr_td || wr_gl || wr_pil) && !priv_mode_i)
      viol_d = 1'b1; // see RULE18
    else if (wr_td)
      trap_depth_d = wr_td_low; // see RULE3 RULE5
    else if (wr_gl)
      gl_d = wr_gl_val[1:0]; // see RULE14
    else if (wr_pil)
      threshold_d = wr_data_i[INT_LW-1:0];
  end

  // Architectural state registers
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      trap_depth_q           <= `TRAP_DEPTH_RST;
      gl_q                   <= 2'h0;
      threshold_q            <= `INT_THRESHOLD_RST;
      priv_instr_violation_o <= 1'b0;
    end
    else
    begin
      trap_depth_q           <= trap_depth_d; // see RULE2
      gl_q                   <= gl_d; // see RULE11
      threshold_q            <= threshold_d;
      priv_instr_violation_o <= viol_d;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rd_data_o <= 64'h0000_0000_0000_0000;
    else
    begin
      case (rd_reg_i)
        `PREG_TRAP_DEPTH:    rd_data_o <= {62'h0, trap_depth_q};
        `PREG_GLOBAL_SET:    rd_data_o <= {62'h0, gl_q}; // see RULE12
        `PREG_INT_THRESHOLD: rd_data_o <= {{(64-INT_LW){1'b0}}, threshold_q};
        default:             rd_data_o <= 64'h0000_0000_0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Interrupt level acceptance
  // ****************************************************************
  int_level_select #(
    .LW (INT_LW)
  ) u_int_sel (
    .pending_i   (int_pending_i),
    .threshold_i (threshold_q), // see RULE7
    .take_o      (int_take_o), // see RULE8
    .level_o     (int_level_o)
  );

  // Status outputs; counters kept independent
  assign trap_depth_o       = trap_depth_q; // see RULE13
  assign in_trap_o          = (trap_depth_q != 2'h0); // see RULE1
  assign global_set_level_o = {1'b0, gl_q};

endmodule

// File: shared/trap_state_defines.vh
`ifndef TRAP_STATE_DEFINES_VH
`define TRAP_STATE_DEFINES_VH

// Privileged register numbers
`define PREG_TRAP_DEPTH      5'h07
`define PREG_INT_THRESHOLD   5'h08
`define PREG_GLOBAL_SET      5'h10

// Architectural limits
`define MAX_TRAP_DEPTH       2'h2
`define MAX_GLOBAL_SET       3'h2

// Field widths
`define TRAP_DEPTH_W         2
`define GLOBAL_SET_W         3
`define INT_LEVEL_W          4

// Reset values
`define TRAP_DEPTH_RST       2'h0
`define GLOBAL_SET_RST       3'h0
`define INT_THRESHOLD_RST    4'hf

`endif

// File: rtl/saved_gl_mem.v
`timescale 1ns/10ps
// ****************************************************************
// Per-depth saved global-set levels
// ****************************************************************
module saved_gl_mem #(
  parameter DEPTH = 3,
  parameter AW    = 2,
  parameter DW    = 3
) (
  input  wire          clk_i,
  input  wire          reset_n_i,
  input  wire          wr_en_i,
  input  wire [AW-1:0] wr_addr_i,
  input  wire [DW-1:0] wr_data_i,
  input  wire [AW-1:0] rd_addr_i,
  output reg  [DW-1:0] rd_data_o
);

  reg [DW-1:0] mem_q [0:DEPTH-1];

  // Entry storage, one register per depth
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1)
    begin : entry
      always @(posedge clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
          mem_q[g] <= {DW{1'b0}};
        else if (wr_en_i && ({{(32-AW){1'b0}}, wr_addr_i} == g))
          mem_q[g] <= wr_data_i;
      end
    end
  endgenerate

  // Registered read port
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rd_data_o <= {DW{1'b0}};
    else if (rd_addr_i < DEPTH)
      rd_data_o <= mem_q[rd_addr_i];
    else
      rd_data_o <= {DW{1'b0}};
  end

endmodule

// File: rtl/int_level_select.v
`timescale 1ns/10ps
// ****************************************************************
// Highest pending interrupt level above threshold
// ****************************************************************
module int_level_select #(
  parameter LW = 4
) (
  input  wire [(1<<LW)-1:0] pending_i,
  input  wire [LW-1:0]      threshold_i,
  output reg                take_o,
  output reg  [LW-1:0]      level_o
);

  integer i;

  // Scan upward so the highest level wins
  always @*
  begin
    take_o  = 1'b0;
    level_o = {LW{1'b0}};
    for (i = 1; i < (1 << LW); i = i + 1)
    begin
      if (pending_i[i] && (i > threshold_i))
      begin
        take_o  = 1'b1;
        level_o = i[LW-1:0];
      end
    end
  end

endmodule

// File: tb/trap_state_asserts.sv
`timescale 1ns/10ps
// ****
// Port checks on the trap state block
// ****
module trap_state_asserts #(
  parameter INT_LW = 4
) (
  input wire                   clk_i,
  input wire                   reset_n_i,
  input wire                   priv_mode_i,
  input wire                   wr_en_i,
  input wire [4:0]             wr_reg_i,
  input wire [63:0]            wr_data_i,
  input wire                   trap_entry_i,
  input wire                   trap_return_i,
  input wire [(1<<INT_LW)-1:0] int_pending_i,
  input wire                   int_take_o,
  input wire [INT_LW-1:0]      int_level_o,
  input wire [1:0]             trap_depth_o,
  input wire                   in_trap_o,
  input wire [2:0]             global_set_level_o,
  input wire                   priv_instr_violation_o
);
  wire [2:0] low_data = wr_data_i[2:0];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Write with no trap event at the same edge
  sequence s_wr(p, r);
    wr_en_i && priv_mode_i == p && wr_reg_i == r && !trap_entry_i && !trap_return_i;
  endsequence
  property p_in_trap; in_trap_o == (trap_depth_o != 2'h0); endproperty
  property p_depth_clamp; s_wr(1, 5'h07) ##0 wr_data_i > 64'h2 |=> trap_depth_o == 2'h2; endproperty
  property p_depth_only; s_wr(1, 5'h07) |=> $stable(global_set_level_o); endproperty
  property p_gl_wr;
    s_wr(1, 5'h10) |=> global_set_level_o == ($past(wr_data_i) > 64'h2 ? 3'h2 : $past(low_data));
  endproperty
  property p_nonpriv;
    s_wr(0, 5'h10) |=> priv_instr_violation_o && $stable(global_set_level_o);
  endproperty
  property p_entry;
    trap_entry_i && trap_depth_o != 2'h2 |=> trap_depth_o == $past(trap_depth_o) + 2'h1;
  endproperty
  property p_entry_gl;
    trap_entry_i && global_set_level_o != 3'h2 |=>
      global_set_level_o == $past(global_set_level_o) + 3'h1;
  endproperty
  property p_int_top; int_take_o |-> (int_pending_i >> int_level_o) == 1; endproperty
  a_in_trap: assert property (p_in_trap) else $error("in_trap wrong");
  a_depth_clamp: assert property (p_depth_clamp) else $error("depth clamp");
  a_depth_only: assert property (p_depth_only) else $error("depth side effect");
  a_gl_wr: assert property (p_gl_wr) else $error("global set write");
  a_nonpriv: assert property (p_nonpriv) else $error("nonpriv write");
  a_entry: assert property (p_entry) else $error("entry depth");
  a_entry_gl: assert property (p_entry_gl) else $error("entry global set");
  a_int_top: assert property (p_int_top) else $error("interrupt level");
endmodule

// File: tb/trap_seq_model.sv
`timescale 1ns/10ps
// ****
// Trap sequencer: one entry or return pulse after a delay
// ****
module trap_seq_model (
  input  wire       clk_i,
  input  wire       go_i,
  input  wire       kind_i,
  input  wire [2:0] lat_i,
  output reg        trap_entry_o,
  output reg        trap_return_o
);
  initial
  begin
    trap_entry_o = 1'b0;
    trap_return_o = 1'b0;
  end
  // Waits lat_i cycles, then a one cycle pulse
  always @(posedge clk_i)
    if (go_i)
    begin
      @(negedge clk_i);
      repeat (lat_i) @(negedge clk_i);
      trap_entry_o <= !kind_i;
      trap_return_o <= kind_i;
      @(negedge clk_i);
      trap_entry_o <= 1'b0;
      trap_return_o <= 1'b0;
    end
endmodule

// File: tb/tb.sv
`timescale 1ns/10ps
// ****
// Bench for the trap and global level state
// ****
module tb;
  reg         clk_i, reset_n_i, priv_mode_i, wr_en_i, saved_gl_wr_i, go, kind, pend;
  reg  [4:0]  wr_reg_i, rd_reg_i;
  reg  [63:0] wr_data_i, v;
  reg  [1:0]  saved_gl_idx_i;
  reg  [2:0]  saved_gl_data_i, lat;
  reg  [15:0] int_pending_i;
  wire [63:0] rd_data_o;
  wire [3:0]  int_level_o;
  wire [2:0]  saved_gl_o;
  wire        int_take_o, trap_entry_i, trap_return_i;
  integer     n_mismatch, n_compared, d, g, i, j, e;
  integer     sv [0:2];
  reg  [63:0] exp_q [$];
  trap_and_global_level_state u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .priv_mode_i(priv_mode_i), .wr_en_i(wr_en_i), .wr_reg_i(wr_reg_i), .wr_data_i(wr_data_i),
    .rd_reg_i(rd_reg_i), .rd_data_o(rd_data_o), .trap_entry_i(trap_entry_i),
    .trap_return_i(trap_return_i), .saved_gl_wr_i(saved_gl_wr_i),
    .saved_gl_idx_i(saved_gl_idx_i), .saved_gl_data_i(saved_gl_data_i),
    .saved_gl_o(saved_gl_o),
    .int_pending_i(int_pending_i), .int_take_o(int_take_o), .int_level_o(int_level_o),
    .trap_depth_o(), .in_trap_o(), .global_set_level_o(), .priv_instr_violation_o());
  trap_seq_model u_seq (.clk_i(clk_i), .go_i(go), .kind_i(kind), .lat_i(lat),
    .trap_entry_o(trap_entry_i), .trap_return_o(trap_return_i));
  // Clock
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = !clk_i;
  end
  task chk(input [63:0] x, input [63:0] s, input string nm);
  begin
    n_compared = n_compared + 1;
    if (s !== x)
    begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %s exp %h got %h", nm, x, s);
    end
  end
  endtask
  task stop_test;
  begin
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  // Register write, model updated with the clamps
  task wr(input p, input [4:0] r, input [63:0] x);
  begin
    @(negedge clk_i);
    priv_mode_i = p;
    wr_en_i = 1'b1;
    wr_reg_i = r;
    wr_data_i = x;
    @(negedge clk_i);
    wr_en_i = 1'b0;
    d = (p && r == 5'h07) ? (x > 2 ? 2 : x[1:0]) : d;
    g = (p && r == 5'h10) ? (x > 2 ? 2 : x[2:0]) : g;
  end
  endtask
  // Register read, expectation queued for the monitor
  task rd(input [4:0] r, input [63:0] x);
  begin
    @(negedge clk_i);
    rd_reg_i = r;
    exp_q.push_back(x);
    pend = 1'b1;
    @(negedge clk_i);
    pend = 0;
  end
  endtask
  // Trap entry or return through the sequencer model
  task trap(input k, input [2:0] l);
  begin
    @(negedge clk_i);
    go = 1'b1;
    kind = k;
    lat = l;
    @(negedge clk_i);
    go = 1'b0;
    repeat (l + 1) @(negedge clk_i);
    if (!k) d = d < 2 ? d + 1 : 2;
    if (!k) sv[d] = g;
    g = k ? (sv[d] > 2 ? 2 : sv[d]) : (g < 2 ? g + 1 : 2);
    if (k) d = d > 0 ? d - 1 : 0;
  end
  endtask
  // Monitor of read data
  always @(posedge clk_i)
    if (pend)
    begin
      #1;
      chk(exp_q.pop_front(), rd_data_o, "rd_data");
    end
  // Watchdog
  initial
  begin
    #100000;
    n_mismatch = n_mismatch + 1;
    stop_test;
  end
  // Main sequence
  initial
  begin
    {reset_n_i, wr_en_i, saved_gl_wr_i, go, kind, pend, lat, wr_reg_i, rd_reg_i} = 0;
    {wr_data_i, saved_gl_idx_i, saved_gl_data_i, int_pending_i, d, g, e} = 0;
    {n_mismatch, n_compared} = 0;
    priv_mode_i = 1'b1;
    v = $urandom(49161);
    repeat (12) @(negedge clk_i);
    reset_n_i = 1'b1;
    rd(5'h08, 64'hf);
    rd(5'h07, 64'h0);
    for (i = 0; i < 12; i = i + 1)
    begin
      v = i < 8 ? i : {$urandom, $urandom};
      wr(1'b1, 5'h07, v);
      rd(5'h07, d);
      wr(1'b1, 5'h10, v ^ 64'h1);
      rd(5'h10, g);
      rd(5'h07, d);
    end
    wr(1'b1, 5'h07, 64'h0);
    wr(1'b1, 5'h10, 64'h1);
    wr(1'b0, 5'h10, 64'h2);
    wr(1'b0, 5'h07, 64'h1);
    priv_mode_i = 1'b1;
    rd(5'h10, 64'h1);
    rd(5'h07, 64'h0);
    for (i = 0; i < 3; i = i + 1)
    begin
      trap(1'b0, i);
      rd(5'h07, d);
      rd(5'h10, g);
    end
    for (j = 0; j < 3; j = j + 1)
    begin
      @(negedge clk_i);
      saved_gl_wr_i = 1'b1;
      saved_gl_idx_i = j;
      saved_gl_data_i = 3'h5 >> j;
      sv[j] = 5 >> j;
      @(negedge clk_i);
      saved_gl_wr_i = 1'b0;
    end
    // Saved entries read back one cycle after the index
    for (j = 0; j < 3; j = j + 1)
    begin
      @(negedge clk_i);
      saved_gl_idx_i = j;
      @(negedge clk_i);
      chk(5 >> j, saved_gl_o, "saved_gl");
    end
    for (i = 0; i < 4; i = i + 1)
    begin
      trap(1'b1, i);
      rd(5'h10, g);
      rd(5'h07, d);
    end
    for (i = 0; i < 16; i = i + 1)
    begin
      wr(1'b1, 5'h08, i);
      int_pending_i = $urandom;
      #1;
      e = -1;
      for (j = i + 1; j < 16; j = j + 1)
        if (int_pending_i[j]) e = j;
      chk(e >= 0, int_take_o, "int_take");
      if (e >= 0) chk(e, int_level_o, "int_level");
    end
    stop_test;
  end
endmodule
bind trap_and_global_level_state trap_state_asserts #(.INT_LW(INT_LW)) u_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .priv_mode_i(priv_mode_i), .wr_en_i(wr_en_i),
  .wr_reg_i(wr_reg_i), .wr_data_i(wr_data_i), .trap_entry_i(trap_entry_i),
  .trap_return_i(trap_return_i), .int_pending_i(int_pending_i), .int_take_o(int_take_o),
  .int_level_o(int_level_o), .trap_depth_o(trap_depth_o), .in_trap_o(in_trap_o),
  .global_set_level_o(global_set_level_o), .priv_instr_violation_o(priv_instr_violation_o));
